//--- verilog/rtc_ctrl_regs.svh
// Purpose: Register offsets, field positions, reset values and timing figures
// Assumes: Four-bit address and data bus, 250 MHz system clock
// Notes:   Definitions only
`ifndef RTC_CTRL_REGS_SVH
`define RTC_CTRL_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RTC_ADDR_TEST      4'h0
`define RTC_ADDR_LEAP      4'hd
`define RTC_ADDR_RUN       4'he
`define RTC_ADDR_INT       4'hf

// ****************************************************************
// Field positions
// ****************************************************************
`define RTC_BIT_REPEAT     3
`define RTC_BIT_FLAG       3
`define RTC_BIT_TEST       3
`define RTC_BIT_RUN        0
`define RTC_SEL_HALF       0
`define RTC_SEL_FIVE       1
`define RTC_SEL_LONG       2

// ****************************************************************
// Reset values
// ****************************************************************
`define RTC_RST_SEL        3'h0
`define RTC_RST_NIBBLE     4'h0
`define RTC_RST_RUN        1'b0
`define RTC_RST_TEST       1'b0
`define RTC_RST_CNT        36'h0

// ****************************************************************
// Timing figures: intervals in ms, clock in kHz
// ****************************************************************
`define RTC_HALF_MS        64'd500
`define RTC_FIVE_MS        64'd5000
`define RTC_LONG_MS        64'd60000
`define RTC_CLK_KHZ        64'd250000
`define RTC_CNT_ONE        36'h1

`endif

//--- verilog/rtc_ctrl_pkg.sv
// Purpose: Shared types of the interrupt and control block
// Assumes: Constants live in rtc_ctrl_regs.svh
// Notes:   One-hot interval timer states
package rtc_ctrl_pkg;

  // Interval timer states, one-hot
  typedef enum logic [3:0]
  {
    TMR_IDLE      = 4'b0001,
    TMR_TIMING    = 4'b0010,
    TMR_WAIT_STAT = 4'b0100,
    TMR_WAIT_NEXT = 4'b1000
  } rtc_tmr_state_e;

  typedef logic [35:0] rtc_cnt_t;

endpackage

//--- verilog/rtc_pin_filter.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps

module rtc_pin_filter
#(
  parameter int          WIDTH = 3,
  parameter logic [2:0]  INIT  = 3'h7
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_lvl
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // ****************************************************************
  // Synchroniser chain; first stage feeds only the second
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_ff <= INIT[WIDTH-1:0];
      s2_ff <= INIT[WIDTH-1:0];
      s3_ff <= INIT[WIDTH-1:0];
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_lvl <= INIT[WIDTH-1:0];
    else
      pin_lvl <= (s2_ff & ~(s2_ff ^ s3_ff)) |
                 (pin_lvl & (s2_ff ^ s3_ff));
  end

endmodule

//--- verilog/rtc_ctrl.sv
// Purpose: Interval interrupt timer, leap-year, run and test control of the clock
// Assumes: Bus pins are asynchronous; data and address stable around strobes
// Notes:   Interval counts are parameters so simulation can shorten them
`timescale 1ns/1ps

`include "rtc_ctrl_regs.svh"

// Contract
// [R01] Write at 15: bits 2..0 pick 0.5 s, 5 s, 60 s interval; zero disables
// [R02] Bit 3 zero: timer stops after one period until software rewrites it
// [R03] Bit 3 one: timer restarts on the read strobe after the status read
// [R04] Read at 15 returns interval echo and interrupt-occurred flag in bit 3
// [R05] Host initialises by writing no-interrupt then reading 15 three times
// [R06] Write at 13 loads the one-hot write-only leap-year state
// [R07] Bit 0 at address 14 starts or stops the clock
// [R08] Host leaves test mode by writing bit 3 zero at address 0
// [R09] Address 15 accepts both reads and writes
// [R10] Open-drain interrupt pulls low on expiry, cleared by status read
// [R11] Interrupt flag clears on the trailing edge of the status read strobe
// [R12] Four-bit registers, four-bit address, low chip select, read and write strobes
module rtc_ctrl
  import rtc_ctrl_pkg::*;
#(
  parameter rtc_cnt_t HALF_CYC = 36'(`RTC_HALF_MS * `RTC_CLK_KHZ),
  parameter rtc_cnt_t FIVE_CYC = 36'(`RTC_FIVE_MS * `RTC_CLK_KHZ),
  parameter rtc_cnt_t LONG_CYC = 36'(`RTC_LONG_MS * `RTC_CLK_KHZ)
)
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,
  input  wire logic       chip_sel_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  output logic            int_out,
  output logic            int_oe,
  output logic      [3:0] leap_year_state,
  output logic            clock_run,
  output logic            test_mode
);

  // ****************************************************************
  // Pin synchronisation and strobe edges
  // ****************************************************************
  logic [2:0]     pin_lvl;
  logic [2:0]     pin_prev_ff;
  logic           wr_lead;
  logic           wr_trail;
  logic           rd_lead;
  logic           rd_trail;
  logic           wr_sel_ff;
  logic           rd_sel_ff;
  logic [3:0]     wr_addr_ff;
  logic [3:0]     rd_addr_ff;
  logic           wr_go;
  logic           wr_int;
  logic           rd_int;
  logic           rd_int_done;
  logic [2:0]     sel_ff;
  logic           repeat_ff;
  logic           flag_ff;
  logic           int_ff;
  logic           expire;
  rtc_cnt_t       cnt_ff;
  rtc_tmr_state_e state_ff;
  rtc_tmr_state_e nxt_state;

  // Bit 2 chip select, bit 1 write strobe, bit 0 read strobe
  rtc_pin_filter #(.WIDTH(3), .INIT(3'h7)) u_pin_filter
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin_in  ({chip_sel_n, write_strobe_n, read_strobe_n}),
    .pin_lvl (pin_lvl)
  );

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_prev_ff <= 3'h7;
    else
      pin_prev_ff <= pin_lvl;
  end

  assign wr_lead  = pin_prev_ff[1] & ~pin_lvl[1];
  assign wr_trail = ~pin_prev_ff[1] & pin_lvl[1];
  assign rd_lead  = pin_prev_ff[0] & ~pin_lvl[0];
  assign rd_trail = ~pin_prev_ff[0] & pin_lvl[0];

  // ****************************************************************
  // Cycle capture: select and address at the leading edge
  // ****************************************************************
  // Chip select is caught early; it may rise soon after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_sel_ff  <= 1'b0;
      rd_sel_ff  <= 1'b0;
      wr_addr_ff <= `RTC_RST_NIBBLE;
      rd_addr_ff <= `RTC_RST_NIBBLE;
    end
    else
    begin
      if (wr_lead)
      begin
        wr_sel_ff  <= ~pin_lvl[2]; // R12
        wr_addr_ff <= addr;
      end
      if (rd_lead)
      begin
        rd_sel_ff  <= ~pin_lvl[2]; // R12
        rd_addr_ff <= addr;
      end
    end
  end

  // Writes take effect at the trailing edge, where data is valid
  assign wr_go       = wr_trail & wr_sel_ff;
  assign wr_int      = wr_go & (wr_addr_ff == `RTC_ADDR_INT); // R09
  assign rd_int      = rd_lead & ~pin_lvl[2] & (addr == `RTC_ADDR_INT); // R09
  assign rd_int_done = rd_trail & rd_sel_ff & (rd_addr_ff == `RTC_ADDR_INT);

  // ****************************************************************
  // Write-only control registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      leap_year_state <= `RTC_RST_NIBBLE;
      clock_run       <= `RTC_RST_RUN;
      test_mode       <= `RTC_RST_TEST;
    end
    else if (wr_go)
    begin
      if (wr_addr_ff == `RTC_ADDR_LEAP)
        leap_year_state <= data_in; // R06
      else if (wr_addr_ff == `RTC_ADDR_RUN)
        clock_run <= data_in[`RTC_BIT_RUN]; // R07
      else if (wr_addr_ff == `RTC_ADDR_TEST)
        test_mode <= data_in[`RTC_BIT_TEST]; // R08
    end
  end

  // Interval selection and mode
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_ff    <= `RTC_RST_SEL;
      repeat_ff <= 1'b0;
    end
    else if (wr_int)
    begin
      sel_ff    <= data_in[2:0]; // R01
      repeat_ff <= data_in[`RTC_BIT_REPEAT]; // R02 R03
    end
  end

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  // Non one-hot codes resolve to the longest selected interval
  function automatic rtc_cnt_t limit_of(input logic [2:0] sel);
    if (sel[`RTC_SEL_LONG])
      limit_of = LONG_CYC;
    else if (sel[`RTC_SEL_FIVE])
      limit_of = FIVE_CYC;
    else
      limit_of = HALF_CYC;
  endfunction

  assign expire = (state_ff == TMR_TIMING) && !wr_int &&
                  (cnt_ff >= limit_of(sel_ff) - `RTC_CNT_ONE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TMR_IDLE:      nxt_state = TMR_IDLE;
      TMR_TIMING:
      begin
        if (expire)
          nxt_state = repeat_ff ? TMR_WAIT_STAT : TMR_IDLE; // R02 R03
      end
      TMR_WAIT_STAT:
      begin
        if (rd_int_done)
          nxt_state = TMR_WAIT_NEXT; // R03
      end
      TMR_WAIT_NEXT:
      begin
        if (rd_trail)
          nxt_state = TMR_TIMING; // R03
      end
      default:       nxt_state = TMR_IDLE;
    endcase
    // A write always rearms or disables the timer
    if (wr_int)
      nxt_state = (data_in[2:0] != `RTC_RST_SEL) ? TMR_TIMING : TMR_IDLE; // R01
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_ff <= TMR_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Counter runs only while timing; restarts from zero on entry to timing, but a rewrite while already timing keeps the count
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_ff <= `RTC_RST_CNT;
    else if (nxt_state != TMR_TIMING || state_ff != TMR_TIMING || expire)
      cnt_ff <= `RTC_RST_CNT;
    else
      cnt_ff <= cnt_ff + `RTC_CNT_ONE;
  end

  // ****************************************************************
  // Interrupt flag and open-drain output
  // ****************************************************************
  // Expiry wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_ff <= 1'b0;
      int_ff  <= 1'b0;
    end
    else if (expire)
    begin
      flag_ff <= 1'b1; // R04
      int_ff  <= 1'b1; // R10
    end
    else if (rd_int_done)
    begin
      flag_ff <= 1'b0; // R11
      int_ff  <= 1'b0; // R10
    end
  end

  assign int_out = 1'b0;
  assign int_oe  = int_ff; // R10

  // ****************************************************************
  // Read path: only the status location is driven by this block
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_out <= `RTC_RST_NIBBLE;
      data_oe  <= 1'b0;
    end
    else
    begin
      if (rd_int)
      begin
        data_out <= {flag_ff, sel_ff}; // R04
        data_oe  <= 1'b1; // R12
      end
      else if (rd_trail || pin_lvl[0])
        data_oe  <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_interval_load: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
    wr_int |=> sel_ff == $past(data_in[2:0]))
    else $error("interval select not loaded");

  a_disable_idle: assert property (@(posedge sys_clk) disable iff (!reset_n) // R01
    wr_int && data_in[2:0] == `RTC_RST_SEL |=> state_ff == TMR_IDLE)
    else $error("zero select did not disable timer");

  a_single_stop: assert property (@(posedge sys_clk) disable iff (!reset_n) // R02
    expire && !repeat_ff |=> state_ff == TMR_IDLE ##1 state_ff == TMR_IDLE)
    else $error("single shot timer kept running");

  a_repeat_restart: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
    state_ff == TMR_WAIT_NEXT && rd_trail && !wr_int |=>
      state_ff == TMR_TIMING && cnt_ff == `RTC_RST_CNT)
    else $error("repeat timer did not restart");

  a_status_echo: assert property (@(posedge sys_clk) disable iff (!reset_n) // R04
    rd_int |=> data_oe && data_out == {$past(flag_ff), $past(sel_ff)})
    else $error("status read data wrong");

  a_leap_load: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
    wr_go && wr_addr_ff == `RTC_ADDR_LEAP |=> leap_year_state == $past(data_in))
    else $error("leap-year state not loaded");

  a_run_ctrl: assert property (@(posedge sys_clk) disable iff (!reset_n) // R07
    wr_go && wr_addr_ff == `RTC_ADDR_RUN |=> clock_run == $past(data_in[`RTC_BIT_RUN]))
    else $error("run control not loaded");

  a_int_pin: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    expire |=> int_oe && flag_ff)
    else $error("interrupt pin not driven on expiry");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    rd_int_done && !expire |=> !flag_ff && !int_oe)
    else $error("flag not cleared by status read");

  a_bus_select: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    $rose(data_oe) |-> !$past(pin_lvl[2]) && $past(addr) == `RTC_ADDR_INT)
    else $error("data driven without select at status address");

endmodule

//--- testbench/rtc_host_model.sv
// Purpose: Host processor model on the four-bit register bus
// Assumes: Block sees the pins through synchronisers, so strobes are long
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps

module rtc_host_model
(
  input  wire logic       sys_clk,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe,
  output logic      [3:0] addr,
  output logic            chip_sel_n,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic      [3:0] data_in
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle bus at time zero
  initial
  begin
    addr = 4'h0;
    chip_sel_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    data_in = 4'h0;
  end

  // Data held well past the strobe, the block samples it late
  task automatic bus_write(input logic [3:0] a, input logic [3:0] d, input logic cs);
    @(posedge sys_clk);
    addr <= a;
    chip_sel_n <= cs;
    data_in <= d;
    repeat (2) @(posedge sys_clk);
    write_strobe_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    write_strobe_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chip_sel_n <= 1'b1;
    data_in <= ~d;
    addr <= ~a;
  endtask

  // Bounded wait for the drive; oe stays low for undriven places
  task automatic bus_read(input logic [3:0] a, output logic [3:0] d, output logic oe);
    @(posedge sys_clk);
    addr <= a;
    chip_sel_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    read_strobe_n <= 1'b0;
    oe = 1'b0;
    d = 4'h0;
    for (int i = 0; i < 10 && !oe; i++)
    begin
      @(posedge sys_clk);
      oe = data_oe;
      d = data_out;
    end
    repeat (4) @(posedge sys_clk);
    read_strobe_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chip_sel_n <= 1'b1;
    addr <= ~a;
  endtask

  // Power-up: no-interrupt setting, three status reads, normal mode
  task automatic host_init();
    logic [3:0] d;
    logic       oe;
    bus_write(4'hf, 4'h0, 1'b0);
    repeat (3) bus_read(4'hf, d, oe);
    bus_write(4'h0, 4'h0, 1'b0);
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench for the interrupt and control block
// Assumes: Intervals shortened to 20, 40 and 60 cycles
// Notes:   Expiry times checked in a window, the pins add latency
`timescale 1ns/1ps

module tb
  import rtc_ctrl_pkg::*;
;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] addr;
  logic       chip_sel_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic       data_oe;
  logic       int_out;
  logic       int_oe;
  logic [3:0] leap_year_state;
  logic       clock_run;
  logic       test_mode;
  logic [3:0] rd_data;
  logic       rd_oe;
  int         errors = 0;
  int         samples_checked = 0;
  int         n;
  int         lim;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  rtc_ctrl #(.HALF_CYC(36'd20), .FIVE_CYC(36'd40), .LONG_CYC(36'd60)) rtc_ctrl_inst
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .chip_sel_n(chip_sel_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .int_out(int_out),
    .int_oe(int_oe), .leap_year_state(leap_year_state), .clock_run(clock_run),
    .test_mode(test_mode)
  );

  rtc_host_model rtc_host_model_inst
  (
    .sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .addr(addr),
    .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .data_in(data_in)
  );

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] v, input logic cs = 1'b0);
    rtc_host_model_inst.bus_write(a, v, cs);
  endtask

  task automatic rd(input logic [3:0] a);
    rtc_host_model_inst.bus_read(a, rd_data, rd_oe);
  endtask

  // Bounded wait for the interrupt pin; n counts the cycles
  task automatic wait_int(input int bound);
    n = 0;
    while (int_oe !== 1'b1 && n < bound)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // Hang guard, the long waits are all bounded anyway
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check("reset outputs", {int_oe, clock_run, test_mode, data_oe}, 4'h0);
    check("reset leap", leap_year_state, 4'h0);
    rd(4'hf);
    check("reset status", rd_data, 4'h0);
    check("status driven", {3'h0, rd_oe}, 4'h1);
    wr(4'h0, 4'h8);
    check("test set", {3'h0, test_mode}, 4'h1);
    rtc_host_model_inst.host_init();
    check("test clear", {3'h0, test_mode}, 4'h0);
    wr(4'he, 4'h1);
    check("run on", {3'h0, clock_run}, 4'h1);
    wr(4'he, 4'he);
    check("run off", {3'h0, clock_run}, 4'h0);
    for (int i = 3; i >= 0; i--)
    begin
      wr(4'hd, 4'h1 << i);
      check("leap", leap_year_state, 4'h1 << i);
    end
    // Deselected or misaddressed writes must not land
    wr(4'hd, 4'h4, 1'b1);
    check("leap deselected", leap_year_state, 4'h1);
    wr(4'h5, 4'h8);
    check("leap other place", leap_year_state, 4'h1);
    rd(4'hd);
    check("write-only undriven", {3'h0, rd_oe}, 4'h0);
    // Each interval in single mode
    for (int k = 0; k < 3; k++)
    begin
      lim = 20 * (k + 1);
      wr(4'hf, 4'h1 << k);
      wait_int(lim + 10);
      check("expiry time", {3'h0, n >= lim - 8 && n <= lim}, 4'h1);
      check("int pin", {2'h0, int_oe, int_out}, 4'h2);
      rd(4'hf);
      check("status flag", rd_data, 4'h8 | (4'h1 << k));
      check("int cleared", {3'h0, int_oe}, 4'h0);
      rd(4'hf);
      check("flag cleared", rd_data, 4'h1 << k);
      wait_int(lim + 10);
      check("single stops", {3'h0, int_oe}, 4'h0);
    end
    // Repeat mode waits for the read after the status read
    wr(4'hf, 4'hc);
    rd(4'hf);
    check("echo", rd_data, 4'h4);
    wait_int(80);
    rd(4'hf);
    check("repeat flag", rd_data, 4'hc);
    wait_int(80);
    check("held for next read", {3'h0, int_oe}, 4'h0);
    rd(4'h4);
    wait_int(80);
    check("restarted", {3'h0, int_oe}, 4'h1);
    wr(4'hf, 4'h0);
    rd(4'hf);
    check("flag kept by write", rd_data, 4'h8);
    rd(4'hf);
    wait_int(80);
    check("disabled status", rd_data, 4'h0);
    check("disabled pin", {3'h0, int_oe}, 4'h0);
    close_out();
  end
endmodule
